// >>> rtl/cell_port_cfg.svh
// constants for the request/response cell port initiator
`ifndef CELL_PORT_CFG_SVH
`define CELL_PORT_CFG_SVH

// link field widths
`define CP_DATA_W      32
`define CP_ADDR_W      32
`define CP_BE_W        4
`define CP_PLEN_W      9
`define CP_CLEN_W      8
`define CP_CELL_BYTES  3'h4

// command codes
`define CP_CMD_NOP     2'h0
`define CP_CMD_READ    2'h1
`define CP_CMD_WRITE   2'h2
`define CP_CMD_LOCKRD  2'h3

// packet tracker depth and its index width
`define CP_TRK_DEPTH   4
`define CP_TRK_AW      2
`define CP_CIDX_W      10

// answer buffer: word = {seq_err, last, error, data}
`define CP_BUF_W       35
`define CP_BUF_DEPTH   2
`define CP_BUF_ERR_BIT 32
`define CP_BUF_EOP_BIT 33
`define CP_BUF_SEQ_BIT 34

`endif

// >>> rtl/cell_port_pkg.sv
// types shared by the cell port initiator files
package cell_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_SEND = 2'b10
  } req_state_t;

  typedef logic [1:0]  cmd_t;
  typedef logic [31:0] addr_t;
  typedef logic [31:0] data_t;
  typedef logic [8:0]  plen_t;
  typedef logic [7:0]  clen_t;
endpackage : cell_port_pkg

// >>> rtl/pair_buffer.sv
// small valid/ready buffer, two entries by default
`timescale 1ns/100ps
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (pop && !push) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule : pair_buffer
`default_nettype wire

// >>> rtl/cell_port_initiator.sv
// initiator end of the request/response cell port
//
// Overview of operation
// [R1] every link signal sampled on rising clk; cell fields count only with valid
// [R2] last cell of each packet carries end-of-packet 1, earlier cells carry 0
// [R3] writes carry write data per cell; response read data is ignored
// [R4] write responses only carry the error flag, one per request cell
// [R5] fresh address, byte enables and write data presented on every cell
// [R6] no-operation uses command 00; no data on requests or responses
// [R7] locked read makes target lock locations until same initiator accesses them
// [R8] chain length counts packets still to follow; 0 marks the last
// [R9] fixed chain keeps opcode; addresses continue across packets per mode
// [R10] target may merge a fixed chain but still answers every packet
// [R11] an address goes with every cell; no flags means no address relation
// [R12] contiguous mode: next address is previous plus bytes previously moved
// [R13] wrap mode: increment low A+1 bits only, no carry beyond bit A
// [R14] constant mode: address equals start address over packet and chain
// [R15] one response packet per request packet, in request order
// [R16] response packet has as many cells as its request, same order
// [R17] command valid and cell contents held until the cell transfers
// [R18] target-select address bits constant over a packet; a contiguous or no-flag step can carry into them
// [R19] command, mode flags and packet length constant within a packet
// [R20] chain fields constant in a packet; chain length drops by one per packet
// [R21] wrap never without contiguous, never with non power of two length
// [R22] no byte enables outside the packet's address and length range
// [R23] target should hold command acknowledge until the next cycle
// [R24] valid signals low while reset is active; cmdval_o only drops at the first rising clk with reset high
// [R25] a cell moves on each edge where its valid and acknowledge are both high
`include "cell_port_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cell_port_initiator (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // user request
  input  wire logic                 req_valid_i,
  output logic                      req_ready_o,
  input  wire cell_port_pkg::cmd_t  req_cmd_i,
  input  wire cell_port_pkg::addr_t req_addr_i,
  input  wire cell_port_pkg::plen_t req_plen_i,
  input  wire logic                 req_contig_i,
  input  wire logic                 req_wrap_i,
  input  wire logic                 req_const_i,
  input  wire cell_port_pkg::clen_t req_clen_i,
  input  wire logic                 req_cfixed_i,
  output logic                      req_bad_o,
  output logic                      busy_o,
  // user write data
  input  wire logic                 wr_valid_i,
  output logic                      wr_ready_o,
  input  wire cell_port_pkg::data_t wr_data_i,
  // user read answer
  output logic                      rd_valid_o,
  input  wire logic                 rd_ready_i,
  output cell_port_pkg::data_t      rd_data_o,
  output logic                      rd_error_o,
  output logic                      rd_last_o,
  output logic                      rd_seq_err_o,
  // link request channel
  output logic                      cmdval_o,
  input  wire logic                 cmdack_i,
  output cell_port_pkg::addr_t      address_o,
  output logic [`CP_BE_W-1:0]       be_o,
  output cell_port_pkg::cmd_t       cmd_o,
  output logic                      contig_o,
  output logic                      wrap_o,
  output logic                      const_flag_o,
  output cell_port_pkg::plen_t      plen_o,
  output logic                      eop_o,
  output cell_port_pkg::clen_t      clen_o,
  output logic                      cfixed_o,
  output cell_port_pkg::data_t      wdata_o,
  // link response channel
  input  wire logic                 rspval_i,
  output logic                      rspack_o,
  input  wire cell_port_pkg::data_t rdata_i,
  input  wire logic                 reop_i,
  input  wire logic                 rerror_i
);
  import cell_port_pkg::*;

  // bytes one cell moves from a lane offset, capped by what remains
  function automatic logic [2:0] cell_bytes(input logic [1:0] lo, input plen_t rem);
    logic [2:0] room;
    room = `CP_CELL_BYTES - {1'b0, lo};
    if (rem < {6'h0, room}) begin
      cell_bytes = rem[2:0];
    end else begin
      cell_bytes = room;
    end
  endfunction : cell_bytes

  // byte enables covering exactly the bytes that cell moves
  function automatic logic [3:0] cell_be(input logic [1:0] lo, input plen_t rem);
    logic [4:0] m;
    m = (5'h01 << cell_bytes(lo, rem)) - 5'h01;
    cell_be = 4'(m[3:0] << lo);
  endfunction : cell_be

  // address of the following cell for the current mode
  function automatic addr_t next_addr(input addr_t a, input logic [2:0] n,
                                      input logic cst, input logic wrp,
                                      input plen_t pl);
    addr_t m;
    addr_t s;
    m = 32'({pl, 1'b0}) - 32'h1;
    s = a + 32'(n);
    if (cst) begin
      next_addr = a;                             // see [R14]
    end else if (wrp) begin
      next_addr = (a & ~m) | (s & m);            // see [R13]
    end else begin
      next_addr = s;                             // see [R12] [R11]
    end
  endfunction : next_addr

  req_state_t state_ff;
  req_state_t nxt_state;
  addr_t      addr_ff;
  plen_t      rem_ff;
  logic       first_ff;
  logic [`CP_BE_W-1:0] be_ff;
  logic       eop_ff;
  data_t      wdata_ff;
  cmd_t       cmd_ff;
  logic       contig_ff;
  logic       wrap_ff;
  logic       const_ff;
  plen_t      plen_ff;
  clen_t      clen_ff;
  logic       cfixed_ff;
  logic       bad_ff;

  // packet tracker: end-cell index and command of each sent packet
  logic [`CP_CIDX_W-1:0] trk_end_ff [`CP_TRK_DEPTH];
  cmd_t                  trk_cmd_ff [`CP_TRK_DEPTH];
  logic [`CP_TRK_AW-1:0] trk_wr_ff;
  logic [`CP_TRK_AW-1:0] trk_rd_ff;
  logic [`CP_TRK_AW:0]   trk_cnt_ff;
  logic [`CP_CIDX_W-1:0] sent_ff;
  logic [`CP_CIDX_W-1:0] rcvd_ff;

  logic       is_write;
  logic       flags_ok;
  logic       cell_done;
  logic       pkt_done;
  logic       trk_full;
  logic       trk_pop;
  logic       rsp_take;
  logic       seq_err;
  cmd_t       rsp_cmd;
  logic [2:0] cur_bytes;
  logic [`CP_BUF_W-1:0] buf_in;
  logic [`CP_BUF_W-1:0] buf_out;
  logic       buf_ready;

  assign is_write  = (cmd_ff == `CP_CMD_WRITE);
  assign cur_bytes = cell_bytes(addr_ff[1:0], rem_ff);
  // nonzero length; wrap only with contiguous and a power of two length
  assign flags_ok  = (req_plen_i != '0) &&
                     (!req_wrap_i || (req_contig_i &&
                      ((req_plen_i & (req_plen_i - 9'h1)) == '0)));  // see [R21]
  assign cell_done = cmdval_o & cmdack_i;        // see [R25] [R1]
  assign pkt_done  = cell_done & eop_ff;
  assign trk_full  = (trk_cnt_ff == (`CP_TRK_AW+1)'(`CP_TRK_DEPTH));

  // handshake outputs decoded from state
  assign req_ready_o = (state_ff == ST_IDLE);
  assign cmdval_o    = (state_ff == ST_SEND);    // see [R17] [R24]
  assign wr_ready_o  = (state_ff == ST_PREP) && is_write && !(first_ff && trk_full);
  assign busy_o      = (state_ff != ST_IDLE) || (trk_cnt_ff != '0);
  assign req_bad_o   = bad_ff;

  // link fields straight from the held cell registers
  assign address_o    = addr_ff;
  assign be_o         = be_ff;
  assign cmd_o        = cmd_ff;
  assign contig_o     = contig_ff;
  assign wrap_o       = wrap_ff;
  assign const_flag_o = const_ff;
  assign plen_o       = plen_ff;
  assign eop_o        = eop_ff;
  assign clen_o       = clen_ff;
  assign cfixed_o     = cfixed_ff;
  assign wdata_o      = wdata_ff;

  // sequencing: idle, set up a cell, present it until acknowledged
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req_valid_i && flags_ok) begin
          nxt_state = ST_PREP;
        end
      end
      ST_PREP: begin
        // a new packet waits for tracker room; a write waits for data
        if (!(first_ff && trk_full) && (!is_write || wr_valid_i)) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (cell_done) begin
          if (eop_ff && clen_ff == '0) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_PREP;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // refused request: one-cycle pulse, nothing goes on the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_ff <= 1'b0;
    end else begin
      bad_ff <= (state_ff == ST_IDLE) && req_valid_i && !flags_ok;
    end
  end

  // packet header, held over the whole chain; only the chain length counts down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff    <= `CP_CMD_NOP;
      contig_ff <= 1'b0;
      wrap_ff   <= 1'b0;
      const_ff  <= 1'b0;
      plen_ff   <= '0;
      clen_ff   <= '0;
      cfixed_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && req_valid_i && flags_ok) begin
      cmd_ff    <= req_cmd_i;                    // see [R19] [R9]
      contig_ff <= req_contig_i;
      wrap_ff   <= req_wrap_i;
      const_ff  <= req_const_i;
      plen_ff   <= req_plen_i;
      clen_ff   <= req_clen_i;                   // see [R8]
      cfixed_ff <= req_cfixed_i;                 // see [R20]
    end else if (pkt_done && clen_ff != '0) begin
      clen_ff <= clen_ff - 8'h01;                // see [R8] [R20]
    end
  end

  // address and remaining bytes advance only on a transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff  <= '0;
      rem_ff   <= '0;
      first_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && req_valid_i && flags_ok) begin
      addr_ff  <= req_addr_i;
      rem_ff   <= req_plen_i;
      first_ff <= 1'b1;
    end else if (cell_done) begin
      // chains carry on in the packet's own mode; a contiguous step can carry into the top bits
      addr_ff  <= next_addr(addr_ff, cur_bytes, const_ff, wrap_ff,
                            plen_ff);            // see [R5] [R9] [R18]
      rem_ff   <= eop_ff ? plen_ff : rem_ff - 9'(cur_bytes);
      first_ff <= eop_ff;
    end else if (state_ff == ST_SEND) begin
      first_ff <= 1'b0;
    end
  end

  // cell contents latched once so they stay put while waiting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      be_ff    <= '0;
      eop_ff   <= 1'b0;
      wdata_ff <= '0;
    end else if (state_ff == ST_PREP && nxt_state == ST_SEND) begin
      be_ff    <= (cmd_ff == `CP_CMD_NOP) ? '0 :
                  cell_be(addr_ff[1:0], rem_ff); // see [R22] [R6]
      eop_ff   <= (rem_ff == 9'(cur_bytes));     // see [R2]
      wdata_ff <= is_write ? wr_data_i : '0;     // see [R3] [R6] [R17]
    end
  end

  // request cells counted so answers can be matched to packets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sent_ff <= '0;
    end else if (cell_done) begin
      sent_ff <= sent_ff + 1'b1;
    end
  end

  // tracker entries written at each packet end
  always_ff @(posedge clk_i) begin
    if (pkt_done) begin
      trk_end_ff[trk_wr_ff] <= sent_ff;
      trk_cmd_ff[trk_wr_ff] <= cmd_ff;
    end
  end

  assign rsp_take = rspval_i & rspack_o;         // see [R25]
  assign trk_pop  = rsp_take & reop_i & (trk_cnt_ff != '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trk_wr_ff  <= '0;
      trk_rd_ff  <= '0;
      trk_cnt_ff <= '0;
    end else begin
      if (pkt_done) begin
        trk_wr_ff <= trk_wr_ff + 1'b1;
      end
      if (trk_pop) begin
        trk_rd_ff <= trk_rd_ff + 1'b1;
      end
      if (pkt_done && !trk_pop) begin
        trk_cnt_ff <= trk_cnt_ff + 1'b1;
      end else if (trk_pop && !pkt_done) begin
        trk_cnt_ff <= trk_cnt_ff - 1'b1;
      end
    end
  end

  // response cells counted in the same numbering as request cells
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcvd_ff <= '0;
    end else if (rsp_take) begin
      rcvd_ff <= rcvd_ff + 1'b1;
    end
  end

  // answer must not run ahead of requests, and its end must match
  always_comb begin
    seq_err = 1'b0;
    if (rcvd_ff == sent_ff) begin
      seq_err = 1'b1;                            // see [R15]
    end else if (trk_cnt_ff != '0) begin
      seq_err = reop_i ^ (rcvd_ff == trk_end_ff[trk_rd_ff]);  // see [R16]
    end else begin
      seq_err = reop_i;                          // see [R16]
    end
  end

  // head packet's command, or the one still going out
  assign rsp_cmd = (trk_cnt_ff != '0) ? trk_cmd_ff[trk_rd_ff] : cmd_ff;

  // read data only kept for reads; writes and no-ops answer error only
  assign buf_in = {seq_err, reop_i, rerror_i,
                   (rsp_cmd == `CP_CMD_READ || rsp_cmd == `CP_CMD_LOCKRD) ?
                   rdata_i : 32'h0};             // see [R3] [R4] [R6] [R7]

  // acknowledge only with buffer room, so a stalled user loses nothing
  assign rspack_o = buf_ready & !rst_i;

  pair_buffer #(
    .WIDTH (`CP_BUF_W),
    .DEPTH (`CP_BUF_DEPTH)
  ) u_answer_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rspval_i),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_in),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (buf_out)
  );

  // unpack the buffered answer word
  assign rd_data_o    = buf_out[31:0];
  assign rd_error_o   = buf_out[`CP_BUF_ERR_BIT];
  assign rd_last_o    = buf_out[`CP_BUF_EOP_BIT];
  assign rd_seq_err_o = buf_out[`CP_BUF_SEQ_BIT];
endmodule : cell_port_initiator
`default_nettype wire

// >>> test/cell_port_initiator_properties.sv
// concurrent checks on the cell port initiator link ports
`timescale 1ns/100ps
`default_nettype none
module cell_port_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // user side
  input wire logic        req_bad_o,
  // link
  input wire logic        cmdval_o,
  input wire logic        cmdack_i,
  input wire logic [31:0] address_o,
  input wire logic [3:0]  be_o,
  input wire logic [1:0]  cmd_o,
  input wire logic        contig_o,
  input wire logic        wrap_o,
  input wire logic        const_flag_o,
  input wire logic [8:0]  plen_o,
  input wire logic        eop_o,
  input wire logic [7:0]  clen_o,
  input wire logic        cfixed_o,
  input wire logic        rspval_i,
  input wire logic        rspack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // last acknowledged cell
  logic        mid_ff, chain_ff;
  logic [3:0]  last_be_ff;
  logic [7:0]  last_clen_ff;
  logic [18:0] last_hdr_ff, hdr;
  logic [31:0] last_addr_ff, mask, step;
  assign hdr = {address_o[31:28], cmd_o, contig_o, wrap_o, const_flag_o, plen_o, cfixed_o};
  // wrap keeps the bits above A; only the low A+1 bits step
  assign mask = 32'({plen_o, 1'b0}) - 32'h1;
  assign step = last_addr_ff + 32'($countones(last_be_ff));
  // remember each acknowledged cell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mid_ff   <= 1'b0;
      chain_ff <= 1'b0;
    end else if (cmdval_o && cmdack_i) begin
      mid_ff       <= !eop_o;
      chain_ff     <= eop_o && clen_o != 8'h0;
      last_addr_ff <= address_o;
      last_be_ff   <= be_o;
      last_hdr_ff  <= hdr;
      last_clen_ff <= clen_o;
    end
  end
  property p_hold;
    cmdval_o && !cmdack_i |=> cmdval_o && $stable({hdr, address_o, be_o, eop_o, clen_o});
  endproperty
  a_hold: assert property (p_hold) else $error("cell changed while waiting");
  property p_wrapc;
    cmdval_o && wrap_o |-> contig_o && (plen_o & (plen_o - 9'h1)) == 9'h0;
  endproperty
  a_wrapc: assert property (p_wrapc) else $error("illegal wrap");
  property p_nop; cmdval_o && cmd_o == 2'h0 |-> be_o == 4'h0; endproperty
  a_nop: assert property (p_nop) else $error("nop with lanes");
  property p_const; cmdval_o && (mid_ff || chain_ff) && const_flag_o |-> address_o == last_addr_ff;
  endproperty
  a_const: assert property (p_const) else $error("constant address moved");
  property p_contig;
    cmdval_o && mid_ff && contig_o && !wrap_o && !const_flag_o && cmd_o != 2'h0
      |-> address_o == step;
  endproperty
  a_contig: assert property (p_contig) else $error("contiguous step wrong");
  property p_wrap;
    cmdval_o && mid_ff && wrap_o && cmd_o != 2'h0
      |-> address_o == ((last_addr_ff & ~mask) | (step & mask));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap step wrong");
  property p_hdr; cmdval_o && mid_ff |-> hdr == last_hdr_ff && clen_o == last_clen_ff;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header changed in packet");
  property p_chain;
    cmdval_o && chain_ff |-> clen_o == last_clen_ff - 8'h1
      && (!last_hdr_ff[0] || cmd_o == last_hdr_ff[14:13]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain count wrong");
  property p_rst;
    @(posedge clk_i) disable iff (1'b0) rst_i |-> !rspack_o ##1 !cmdval_o;
  endproperty
  a_rst: assert property (p_rst) else $error("valid during reset");
  c_bad: cover property (req_bad_o);
  c_full: cover property (rspval_i && !rspack_o);
  c_chain: cover property (cmdval_o && chain_ff);
endmodule : cell_port_checker
bind cell_port_initiator cell_port_checker chk_u (.*);
`default_nettype wire

// >>> test/cell_target_model.sv
// target model: one answer per request cell, in order, with stalls
`timescale 1ns/100ps
`default_nettype none
module cell_target_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request channel
  input  wire logic        cmdval_i,
  output logic             cmdack_o,
  input  wire logic [31:0] address_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [1:0]  cmd_i,
  input  wire logic        eop_i,
  input  wire logic [31:0] wdata_i,
  // response channel
  output logic             rspval_o,
  input  wire logic        rspack_i,
  output logic [31:0]      rdata_o,
  output logic             reop_o,
  output logic             rerror_o,
  // stall control
  input  wire logic [1:0]  stall_i
);
  logic [31:0] mem[logic [29:0]];
  logic [33:0] rq[$];
  logic [31:0] w;
  // ack decided inside the cycle, so it never drops before the edge
  assign cmdack_o = cmdval_i & ~stall_i[0] & ~rst_i;
  // single initiator: a lock never denies, so locked read acts as read
  always @(posedge clk_i) begin
    if (rst_i) begin
      rq.delete();
      rspval_o <= 1'b0;
    end else begin
      if (cmdval_i && cmdack_o) begin
        w = mem.exists(address_i[31:2]) ? mem[address_i[31:2]] : ~{address_i[31:2], 2'b00};
        for (int i = 0; i < 4; i++)
          if (cmd_i == 2'h2 && be_i[i]) w[8*i +: 8] = wdata_i[8*i +: 8];
        if (cmd_i == 2'h2) mem[address_i[31:2]] = w;
        // no merging; page E answers an error
        rq.push_back({eop_i, address_i[31:28] == 4'hE, cmd_i[0] ? w : ~w});
      end
      if (!rspval_o || rspack_i) begin
        if (rq.size() != 0 && !stall_i[1]) begin
          rspval_o <= 1'b1;
          {reop_o, rerror_o, rdata_o} <= rq.pop_front();
        end else begin
          rspval_o <= 1'b0;
          {reop_o, rerror_o, rdata_o} <= ~{reop_o, rerror_o, rdata_o}; // released lines churn
        end
      end
    end
  end
endmodule : cell_target_model
`default_nettype wire

// >>> test/cell_port_initiator_bench.sv
// self-checking bench: initiator against the target model
`timescale 1ns/100ps
`default_nettype none
module cell_port_initiator_bench;
  import cell_port_pkg::*;
  localparam int LIMIT = 40000;
  logic clk_i = 0, rst_i = 1, req_valid_i = 0, req_contig_i = 0, req_wrap_i = 0;
  logic req_const_i = 0, req_cfixed_i = 0, wr_valid_i = 0, rd_ready_i = 1, took = 0;
  logic cmdack_i, rspval_i, reop_i, rerror_i, req_ready_o, req_bad_o, busy_o, wr_ready_o;
  logic rd_valid_o, rd_error_o, rd_last_o, rd_seq_err_o, cmdval_o, contig_o, wrap_o;
  logic const_flag_o, eop_o, cfixed_o, rspack_o;
  logic [1:0]  stall = 0;
  logic [3:0]  be_o;
  logic [34:0] exq[$];
  cmd_t        req_cmd_i = 0, cmd_o;
  addr_t       req_addr_i = 0, address_o;
  plen_t       req_plen_i = 0, plen_o;
  clen_t       req_clen_i = 0, clen_o;
  data_t       wr_data_i = 0, rd_data_o, wdata_o, rdata_i, wq[$], mem[logic [29:0]];
  int          seed = 97431, miscompares = 0, comparisons = 0, cycles = 0, slow = 0;
  cell_port_initiator dut_u (.*);
  cell_target_model tgt_u (.clk_i, .rst_i, .cmdval_i(cmdval_o), .cmdack_o(cmdack_i),
    .address_i(address_o), .be_i(be_o), .cmd_i(cmd_o), .eop_i(eop_o), .wdata_i(wdata_o),
    .rspval_o(rspval_i), .rspack_i(rspack_o), .rdata_o(rdata_i), .reop_o(reop_i),
    .rerror_o(rerror_i), .stall_i(stall));
  always #50 clk_i = ~clk_i;
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk_word(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected answer at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end
  // far-side stalls; in slow mode the answer buffer fills and refuses
  always @(posedge clk_i) begin
    #1;
    stall = slow ? 2'($random(seed)) : 2'b00;
    rd_ready_i = slow ? ($random(seed) & 7) == 0 : 1'b1;
    if (took) void'(wq.pop_front());
    took = 0;
    wr_valid_i = wq.size() != 0;
    wr_data_i = wq.size() != 0 ? wq[0] : ~wr_data_i;
  end
  // judged mid-cycle, where the outputs have settled
  always @(negedge clk_i) begin
    if (wr_valid_i && wr_ready_o === 1'b1) took = 1;
    if (!rst_i && rd_valid_o === 1'b1 && rd_ready_i) begin
      chk_word({rd_seq_err_o, rd_last_o, rd_error_o, rd_data_o},
               exq.size() != 0 ? exq.pop_front() : 'x);
    end
  end
  // present a request and hold it until taken
  task automatic issue(input cmd_t c, input addr_t a, input plen_t p, input logic [2:0] f,
                       input clen_t cl, input logic cf);
    @(posedge clk_i);
    #1;
    {req_cmd_i, req_addr_i, req_plen_i, req_const_i, req_wrap_i, req_contig_i} = {c, a, p, f};
    {req_clen_i, req_cfixed_i, req_valid_i} = {cl, cf, 1'b1};
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    @(posedge clk_i);
    #1 req_valid_i = 0;
  endtask : issue
  // model each cell, then issue; f is {const, wrap, contig}
  task automatic send(input cmd_t c, input addr_t a, input plen_t p, input logic [2:0] f,
                      input clen_t cl, input logic cf);
    addr_t s, m;
    data_t w, d;
    int    n, rem;
    s = a;
    m = f[1] ? addr_t'({p, 1'b0}) - 32'h1 : '1;
    for (int k = 0; k <= int'(cl); k++) begin
      rem = p;
      while (rem > 0) begin
        n = (4 - a[1:0] < rem) ? 4 - a[1:0] : rem;
        rem -= n;
        w = mem.exists(a[31:2]) ? mem[a[31:2]] : ~{a[31:2], 2'b00};
        d = $random(seed);
        if (c == 2'h2) begin
          wq.push_back(d);
          for (int i = 0; i < 4; i++)
            if (i >= a[1:0] && i < a[1:0] + n) w[8*i +: 8] = d[8*i +: 8];
          mem[a[31:2]] = w;
        end
        exq.push_back({1'b0, rem == 0, a[31:28] == 4'hE, c[0] ? w : 32'h0});
        if (!f[2]) a = (a & ~m) | ((a + n) & m);
      end
    end
    issue(c, s, p, f, cl, cf);
  endtask : send
  // all answers home, then the port is idle
  task automatic drain();
    for (int g = 0; g < 5000 && (exq.size() != 0 || busy_o !== 1'b0); g++) @(negedge clk_i);
    chk_flag(busy_o, 1'b0);
    chk_flag(wq.size() == 0, 1'b1);
  endtask : drain
  // a refused request: one pulse and a quiet link
  task automatic bad(input logic [2:0] f, input plen_t p);
    int pulses, cells;
    pulses = 0;
    cells = 0;
    issue(2'h1, 32'h400, p, f, 8'h0, 1'b0);
    repeat (4) begin
      @(negedge clk_i);
      pulses += (req_bad_o === 1'b1);
      cells += (cmdval_o !== 1'b0);
    end
    chk_flag(pulses == 1 && cells == 0, 1'b1);
  endtask : bad
  initial begin
    addr_t a;
    plen_t p;
    repeat (8) @(posedge clk_i);
    #1 rst_i = 0;
    for (int s = 0; s < 2; s++) begin
      slow = s;
      send(2'h2, 32'h100, 9'd16, 3'b001, 8'h0, 1'b0);
      send(2'h1, 32'h100, 9'd16, 3'b001, 8'h0, 1'b0);
      send(2'h2, 32'h202, 9'd6, 3'b001, 8'h0, 1'b0);
      send(2'h3, 32'h200, 9'd12, 3'b001, 8'h0, 1'b0);
      send(2'h2, 32'h304, 9'd8, 3'b011, 8'h0, 1'b0);
      send(2'h1, 32'h300, 9'd16, 3'b011, 8'h0, 1'b0);
      send(2'h1, 32'h106, 9'd8, 3'b100, 8'h0, 1'b0);
      send(2'h0, 32'h100, 9'd8, 3'b001, 8'h0, 1'b0);
      send(2'h1, 32'h100, 9'd8, 3'b001, 8'h2, 1'b1);
      send(2'h1, 32'h120, 9'd4, 3'b100, 8'h1, 1'b1);
      send(2'h2, 32'hE000_0010, 9'd8, 3'b000, 8'h0, 1'b0);
      drain();
      bad(3'b010, 9'd8);
      bad(3'b011, 9'd6);
      repeat (8) begin
        a = addr_t'($random(seed)) & 32'hFFF;
        p = plen_t'(($random(seed) & 15) + 1);
        send(2'($random(seed)), a, p, {2'b00, 1'($random(seed))}, 8'h0, 1'b0);
      end
      drain();
    end
    summarize();
  end
endmodule : cell_port_initiator_bench
`default_nettype wire
